// >>> design/wcu_consts.svh
// Purpose: constants of the weight conditioning unit
// Assumes: ref_clk at 100 MHz
// Notes: times kept in their own units, counts derived from them
`ifndef WCU_CONSTS_SVH
`define WCU_CONSTS_SVH

// clock period and the 10 ms time base
`define WCU_CLK_NS 10
`define WCU_TICK_NS 10000000
`define WCU_TICK_MS 10
`define WCU_TICKS_PER_SEC 100
`define WCU_TENTH_TICKS 10

// motion detection history steps
`define WCU_STABLE_STEP_S 1
`define WCU_CHECK_STEP_MS 90
`define WCU_STABLE_STEP_TICKS (`WCU_STABLE_STEP_S * `WCU_TICKS_PER_SEC)
`define WCU_CHECK_STEP_TICKS (`WCU_CHECK_STEP_MS / `WCU_TICK_MS)
`define WCU_STABLE_TERMS 5
`define WCU_CHECK_TERMS 3

// display refresh rates per second, and ticks between refreshes
`define WCU_RATE_0 25
`define WCU_RATE_1 13
`define WCU_RATE_2 6
`define WCU_RATE_3 3
`define WCU_DISP_TICKS(r) (`WCU_TICKS_PER_SEC / (r))

// alarm blink half period in ticks
`define WCU_BLINK_TICKS 50

// moving average depth
`define WCU_AVG_DEPTH 256

// zero regulation value after reset
`define WCU_ZERO_REG_RST 14'h00C8

`endif

// >>> design/wcu_pkg.sv
// Purpose: types of the weight conditioning unit
// Assumes: constants live in wcu_consts.svh
// Notes: one-hot alarm states
package wcu_pkg;

	// signed weight in scale counts
	typedef logic signed [23:0] wcu_weight_type;

	// zero limit alarm indicator states
	typedef enum logic [1:0] {
		WCU_ALM_OFF = 2'h1,
		WCU_ALM_FLASH = 2'h2
	} wcu_alarm_type;

	// subdisplay data sets
	typedef enum logic [2:0] {
		WCU_SUB_NONE = 3'h0,
		WCU_SUB_LIMITS = 3'h1,
		WCU_SUB_JUDGE = 3'h2,
		WCU_SUB_CNT_LAST_FINAL = 3'h3,
		WCU_SUB_LAST_TOTAL = 3'h4,
		WCU_SUB_CNT_TOTAL = 3'h5
	} wcu_sub_type;

endpackage

// >>> design/wcu_avg.sv
// Purpose: running moving average over up to 256 samples
// Assumes: avg_len 1..256 when in use
// Notes: a length change restarts the average from empty
`timescale 1ns/1ps
`default_nettype none
`include "wcu_consts.svh"
module wcu_avg (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [8:0] avg_len,
	input wire logic in_valid,
	input wire wcu_pkg::wcu_weight_type in_data,
	output wcu_pkg::wcu_weight_type avg_out
);
	// sample history, not reset: fill count guards stale words
	logic signed [23:0] mem [0:`WCU_AVG_DEPTH-1];
	logic [7:0] wr_ptr; // next slot to write
	logic [8:0] fill; // samples held, up to avg_len
	logic [8:0] last_len; // detects a length change
	logic signed [31:0] sum; // sum of held samples

	wire logic full = fill == avg_len;
	// with length 256 this is the write slot itself, the oldest word
	wire logic [7:0] old_idx = 8'(wr_ptr - avg_len[7:0]);
	wire logic signed [31:0] old_w = full ? 32'(mem[old_idx]) : 32'sh0;
	wire logic signed [31:0] next_sum = sum + 32'(in_data) - old_w;
	wire logic [8:0] next_fill = full ? fill : 9'(fill + 9'h001);
	wire logic len_chg = avg_len != last_len;
	wire logic take = in_valid && !len_chg && avg_len != 9'h000;
	// divider is combinational: area traded for a one-cycle result
	wire logic signed [31:0] quot = next_sum / $signed({23'h0, next_fill});

	// history write
	always_ff @(posedge ref_clk) begin
		if (clk_en && take) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// running sum and result
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= 8'h00;
			fill <= 9'h000;
			last_len <= 9'h000;
			sum <= 32'sh0;
			avg_out <= 24'sh0;
		end else if (clk_en) begin
			last_len <= avg_len;
			if (len_chg) begin
				fill <= 9'h000;
				sum <= 32'sh0;
			end else if (take) begin
				wr_ptr <= 8'(wr_ptr + 8'h01);
				fill <= next_fill;
				sum <= next_sum;
				avg_out <= 24'(quot);
			end
		end
	end
endmodule
`default_nettype wire

// >>> design/wcu_buf.sv
// Purpose: two-entry buffer between weight path and display
// Assumes: single clock, valid/ready on both sides
// Notes: head and spare are flops, so outputs are registered
`timescale 1ns/1ps
`default_nettype none
module wcu_buf #(
	parameter int WIDTH = 48
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic [WIDTH-1:0] spare; // second entry
	logic spare_valid; // second entry holds a word

	// room exists unless the spare is taken
	assign in_ready = !spare_valid;
	wire logic push = in_valid && in_ready;
	wire logic head_free = !out_valid || out_ready;

	// head refills from spare first, keeping order
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'h0;
			out_data <= '0;
			spare <= '0;
			spare_valid <= 1'h0;
		end else if (clk_en) begin
			if (head_free) begin
				if (spare_valid) begin
					out_valid <= 1'h1;
					out_data <= spare;
					spare_valid <= push;
					if (push) begin
						spare <= in_data;
					end
				end else begin
					out_valid <= push;
					if (push) begin
						out_data <= in_data;
					end
				end
			end else if (push) begin
				// receiver stalls: park the word
				spare <= in_data;
				spare_valid <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> design/wcu_top.sv
// Purpose: weight conditioning unit of a weighing controller
// Assumes: samples and keys on ref_clk, contacts asynchronous
// Notes: a 10 ms tick paces every timed behaviour
// Notes on behaviour
// - display refresh 25/13/6/3 per second, processing unchanged
// - subdisplay shows one selected data set
// - moving average, length 0 (off) to 256
// - filter inserted when option on and stable
// - stable only after terms in range period
// - stable mode: five terms, 1 s base
// - checker mode: three terms, 0.09 s base
// - judging period 0.0 to 9.9 seconds
// - motion range is setting times division
// - drift tracking: period 0.0-9.9, range 0-9999
// - forced zeroing zeroes gross, net follows
// - zeroing above regulation value flashes alarm
// - then only regulation value is subtracted
// - contact to common zeroes gross at once
// - regulation value is 200 after reset
// - zero clear removes forced offset, stops alarm
// - limit counts forced and tracked offset together; only tracking checks that sum, forced zeroing compares gross alone
// - tracking beyond limit flashes alarm
// - tare key captures weight, net becomes zero
// - restricted tare accepted only while stable
// - tare range: all, or 0 < tare <= capacity
// - tare contact to common tares at once
`timescale 1ns/1ps
`default_nettype none
`include "wcu_consts.svh"
module wcu_top #(
	parameter int CENTI_CYCLES = `WCU_TICK_NS / `WCU_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en, // low freezes all state
	input wire logic sample_valid, // one converted sample
	input wire logic signed [23:0] sample_data,
	input wire logic [8:0] avg_len, // 0 turns the filter off
	input wire logic stable_insert_en,
	input wire logic motion_checker, // 1 selects checker mode
	input wire logic [6:0] motion_period, // tenths of a second
	input wire logic [6:0] motion_range,
	input wire logic [7:0] min_div,
	input wire logic [6:0] drift_period, // tenths of a second
	input wire logic [13:0] drift_range,
	input wire logic zero_reg_load,
	input wire logic [13:0] zero_reg_in,
	input wire logic forced_zeroing_key,
	input wire logic zero_clear_key,
	input wire logic forced_zeroing_contact_n, // pin, low = closed
	input wire logic tare_key,
	input wire logic tare_contact_n, // pin, low = closed
	input wire logic tare_restrict_en,
	input wire logic tare_range_limited,
	input wire logic [23:0] capacity,
	input wire logic [1:0] disp_rate_sel,
	input wire wcu_pkg::wcu_sub_type subdisp_sel,
	input wire logic [23:0] near_zero_set,
	input wire logic [23:0] upper_set,
	input wire logic [23:0] lower_set,
	input wire logic [23:0] final_set,
	input wire logic [23:0] over_set,
	input wire logic [23:0] under_set,
	input wire logic [23:0] acc_count,
	input wire logic [23:0] acc_latest,
	input wire logic [23:0] acc_total,
	input wire logic disp_ready,
	output logic disp_valid,
	output logic signed [23:0] disp_net,
	output logic signed [23:0] disp_gross,
	output logic [23:0] sub_w0,
	output logic [23:0] sub_w1,
	output logic [23:0] sub_w2,
	output logic motion_stable,
	output logic zero_limit_alarm,
	output logic tare_lit
);
	// 10 ms time base
	logic [19:0] tick_cnt;
	wire logic tick = tick_cnt == 20'(CENTI_CYCLES - 1);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt <= 20'h00000;
		end else if (clk_en) begin
			tick_cnt <= tick ? 20'h00000 : 20'(tick_cnt + 20'h00001);
		end
	end

	// contact synchronisers: stage 0 is read only by stage 1
	logic [2:0] fz_sync;
	logic [2:0] tare_sync;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fz_sync <= 3'h7;
			tare_sync <= 3'h7;
		end else if (clk_en) begin
			fz_sync <= {fz_sync[1:0], forced_zeroing_contact_n};
			tare_sync <= {tare_sync[1:0], tare_contact_n};
		end
	end
	// closing a contact is a falling edge
	wire logic fz_contact_req = fz_sync[2] & ~fz_sync[1];
	wire logic tare_contact_req = tare_sync[2] & ~tare_sync[1];

	// raw sample and history snapshots
	logic signed [23:0] raw_q;
	logic conv_d; // sample_valid one cycle late, avg is then ready
	logic signed [23:0] snap [0:`WCU_STABLE_TERMS-1];
	logic [6:0] step_cnt;
	wire logic [6:0] step_len = motion_checker ?
		7'(`WCU_CHECK_STEP_TICKS) : 7'(`WCU_STABLE_STEP_TICKS);
	wire logic step = tick && (step_cnt >= 7'(step_len - 7'h01));
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			raw_q <= 24'sh0;
			conv_d <= 1'h0;
			step_cnt <= 7'h00;
			for (int i = 0; i < `WCU_STABLE_TERMS; i++) begin
				snap[i] <= 24'sh0;
			end
		end else if (clk_en) begin
			conv_d <= sample_valid;
			if (sample_valid) begin
				raw_q <= sample_data;
			end
			if (tick) begin
				step_cnt <= step ? 7'h00 : 7'(step_cnt + 7'h01);
			end
			// snapshots lie one step apart, oldest last
			if (step) begin
				snap[0] <= raw_q;
				for (int i = 1; i < `WCU_STABLE_TERMS; i++) begin
					snap[i] <= snap[i-1];
				end
			end
		end
	end

	// difference terms against the motion range
	wire logic [24:0] motion_lim = 25'(motion_range * min_div);
	wire logic [2:0] term_cnt = motion_checker ?
		3'(`WCU_CHECK_TERMS) : 3'(`WCU_STABLE_TERMS);
	wire logic [4:0] term_out; // one bit per difference term
	genvar k;
	generate
		for (k = 0; k < `WCU_STABLE_TERMS; k++) begin : g_term
			wire logic signed [24:0] diff = 25'(sample_data) - 25'(snap[k]);
			wire logic [24:0] mag = diff[24] ? 25'(-diff) : 25'(diff);
			// only the mode's own terms take part
			assign term_out[k] = (3'(k) < term_cnt) && (mag > motion_lim);
		end
	endgenerate
	wire logic any_out = sample_valid && (term_out != 5'h00);

	// judging period, counted in ticks
	logic [9:0] motion_cnt;
	wire logic [9:0] motion_need =
		10'(motion_period * 10'(`WCU_TENTH_TICKS));
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			motion_cnt <= 10'h000;
			motion_stable <= 1'h0;
		end else if (clk_en) begin
			if (any_out) begin
				// drop at once and restart the period
				motion_cnt <= 10'h000;
				motion_stable <= 1'h0;
			end else begin
				if (tick && motion_cnt < motion_need) begin
					motion_cnt <= 10'(motion_cnt + 10'h001);
				end
				if (sample_valid && motion_cnt >= motion_need) begin
					motion_stable <= 1'h1;
				end
			end
		end
	end

	// moving average, inserted into the path when allowed
	wcu_pkg::wcu_weight_type avg_w;
	wcu_avg u_avg (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.avg_len(avg_len),
		.in_valid(sample_valid),
		.in_data(sample_data),
		.avg_out(avg_w)
	);
	wire logic use_filter = (avg_len != 9'h000) &&
		(!stable_insert_en || motion_stable);
	logic signed [23:0] path_w; // conditioned weight before zeroing
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			path_w <= 24'sh0;
		end else if (clk_en && conv_d) begin
			path_w <= use_filter ? avg_w : raw_q;
		end
	end

	// zero offsets: forced part and tracked part
	logic signed [23:0] fz_off;
	logic signed [23:0] drift_off;
	logic signed [23:0] tare_q;
	logic [13:0] zero_reg;
	wire logic signed [23:0] zreg_w = {10'h000, zero_reg};
	wire logic signed [23:0] gross = path_w - fz_off - drift_off;
	wire logic signed [23:0] net = gross - tare_q;
	wire logic fz_req = forced_zeroing_key || fz_contact_req;
	wire logic fz_over = gross > zreg_w;
	wire logic signed [23:0] fz_step = fz_over ? zreg_w : gross;

	// drift tracking near zero
	logic [9:0] drift_cnt;
	wire logic [9:0] drift_need =
		10'(drift_period * 10'(`WCU_TENTH_TICKS));
	wire logic [23:0] gross_mag = gross[23] ? 24'(-gross) : 24'(gross);
	wire logic drift_near = gross_mag <= {10'h000, drift_range};
	wire logic drift_fire = tick && drift_period != 7'h00 && drift_near &&
		(drift_cnt >= 10'(drift_need - 10'h001));
	// limit applies to both offsets taken together
	wire logic signed [23:0] total_off = fz_off + drift_off + gross;
	wire logic [23:0] total_mag =
		total_off[23] ? 24'(-total_off) : 24'(total_off);
	wire logic drift_block = drift_fire &&
		(total_mag > {10'h000, zero_reg});
	// forced zeroing wins so gross is not taken twice
	wire logic drift_shift = drift_fire && !drift_block && !fz_req;

	// offset registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fz_off <= 24'sh0;
			drift_off <= 24'sh0;
			drift_cnt <= 10'h000;
			zero_reg <= `WCU_ZERO_REG_RST;
		end else if (clk_en) begin
			if (zero_reg_load) begin
				zero_reg <= zero_reg_in;
			end
			// a request in the clear cycle is kept
			if (fz_req) begin
				fz_off <= 24'(fz_off + fz_step);
			end else if (zero_clear_key) begin
				fz_off <= 24'sh0;
			end
			if (drift_shift) begin
				drift_off <= 24'(drift_off + gross);
			end
			if (tick) begin
				if (!drift_near || drift_period == 7'h00 || drift_fire) begin
					drift_cnt <= 10'h000;
				end else begin
					drift_cnt <= 10'(drift_cnt + 10'h001);
				end
			end
		end
	end

	// zero limit alarm: set wins over clear
	wcu_pkg::wcu_alarm_type alarm_state;
	wcu_pkg::wcu_alarm_type next_alarm;
	wire logic alarm_set = (fz_req && fz_over) || drift_block;
	always_comb begin
		next_alarm = alarm_state;
		case (alarm_state)
			wcu_pkg::WCU_ALM_OFF: begin
				if (alarm_set) begin
					next_alarm = wcu_pkg::WCU_ALM_FLASH;
				end
			end
			wcu_pkg::WCU_ALM_FLASH: begin
				if (zero_clear_key && !alarm_set) begin
					next_alarm = wcu_pkg::WCU_ALM_OFF;
				end
			end
			default: begin
				next_alarm = wcu_pkg::WCU_ALM_OFF;
			end
		endcase
	end

	// blink phase and alarm output
	logic [5:0] blink_cnt;
	logic blink_ph;
	wire logic blink_flip = tick && blink_cnt == 6'(`WCU_BLINK_TICKS - 1);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			alarm_state <= wcu_pkg::WCU_ALM_OFF;
			blink_cnt <= 6'h00;
			blink_ph <= 1'h1;
			zero_limit_alarm <= 1'h0;
		end else if (clk_en) begin
			alarm_state <= next_alarm;
			if (tick) begin
				blink_cnt <= blink_flip ? 6'h00 : 6'(blink_cnt + 6'h01);
			end
			if (blink_flip) begin
				blink_ph <= !blink_ph;
			end
			zero_limit_alarm <= (alarm_state == wcu_pkg::WCU_ALM_FLASH) && blink_ph;
		end
	end

	// tare capture
	wire logic tare_req = tare_key || tare_contact_req;
	wire logic tare_ok_stab = !tare_restrict_en || motion_stable;
	wire logic tare_ok_rng = !tare_range_limited ||
		(gross > 24'sh0 && $unsigned(gross) <= capacity);
	wire logic tare_do = tare_req && tare_ok_stab && tare_ok_rng;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tare_q <= 24'sh0;
			tare_lit <= 1'h0;
		end else if (clk_en && tare_do) begin
			tare_q <= gross;
			tare_lit <= 1'h1;
		end
	end

	// subdisplay selection
	wire logic s_lim = subdisp_sel == wcu_pkg::WCU_SUB_LIMITS;
	wire logic s_jdg = subdisp_sel == wcu_pkg::WCU_SUB_JUDGE;
	wire logic s_clf = subdisp_sel == wcu_pkg::WCU_SUB_CNT_LAST_FINAL;
	wire logic s_lat = subdisp_sel == wcu_pkg::WCU_SUB_LAST_TOTAL;
	wire logic s_cat = subdisp_sel == wcu_pkg::WCU_SUB_CNT_TOTAL;
	wire logic [23:0] sub_a = s_lim ? near_zero_set : s_jdg ? final_set :
		(s_clf || s_cat) ? acc_count : s_lat ? acc_latest : 24'h000000;
	wire logic [23:0] sub_b = s_lim ? upper_set : s_jdg ? over_set :
		s_clf ? acc_latest : (s_lat || s_cat) ? acc_total : 24'h000000;
	wire logic [23:0] sub_c = s_lim ? lower_set : s_jdg ? under_set :
		s_clf ? final_set : 24'h000000;

	// display refresh pacing, independent of the sample rate
	logic [5:0] disp_cnt;
	logic disp_pend; // a refresh waits for buffer room
	wire logic [5:0] disp_need =
		disp_rate_sel == 2'h0 ? 6'(`WCU_DISP_TICKS(`WCU_RATE_0)) :
		disp_rate_sel == 2'h1 ? 6'(`WCU_DISP_TICKS(`WCU_RATE_1)) :
		disp_rate_sel == 2'h2 ? 6'(`WCU_DISP_TICKS(`WCU_RATE_2)) :
		6'(`WCU_DISP_TICKS(`WCU_RATE_3));
	wire logic disp_due = tick && disp_cnt >= 6'(disp_need - 6'h01);
	wire logic buf_ready;
	wire logic disp_push = disp_pend && buf_ready;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			disp_cnt <= 6'h00;
			disp_pend <= 1'h0;
			sub_w0 <= 24'h000000;
			sub_w1 <= 24'h000000;
			sub_w2 <= 24'h000000;
		end else if (clk_en) begin
			if (tick) begin
				disp_cnt <= disp_due ? 6'h00 : 6'(disp_cnt + 6'h01);
			end
			if (disp_due) begin
				disp_pend <= 1'h1;
			end else if (disp_push) begin
				disp_pend <= 1'h0;
			end
			if (disp_push) begin
				sub_w0 <= sub_a;
				sub_w1 <= sub_b;
				sub_w2 <= sub_c;
			end
		end
	end

	// display words go through the buffer, so a stall loses none
	logic [47:0] buf_data;
	wcu_buf #(.WIDTH(48)) u_buf (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.in_valid(disp_pend),
		.in_data({net, gross}),
		.in_ready(buf_ready),
		.out_valid(disp_valid),
		.out_data(buf_data),
		.out_ready(disp_ready)
	);
	assign disp_net = buf_data[47:24];
	assign disp_gross = buf_data[23:0];

	// checks
	default clocking wcu_cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_motion_drop;
		clk_en && any_out |=> !motion_stable && motion_cnt == 10'h000;
	endproperty
	a_motion_drop: assert property (p_motion_drop)
		else $error("stable kept after an out-of-range term");

	property p_checker_terms;
		motion_checker |-> term_out[4:3] == 2'h0;
	endproperty
	a_checker_terms: assert property (p_checker_terms)
		else $error("checker mode used more than three terms");

	property p_stable_wait;
		$rose(motion_stable) |-> $past(motion_cnt) >= $past(motion_need);
	endproperty
	a_stable_wait: assert property (p_stable_wait)
		else $error("stable set before the judging period");

	property p_insert;
		clk_en && conv_d && stable_insert_en && !motion_stable
			|=> path_w == $past(raw_q);
	endproperty
	a_insert: assert property (p_insert)
		else $error("filter inserted while not stable");

	property p_fz_full;
		clk_en && fz_req && !fz_over
			|=> fz_off == 24'($past(fz_off) + $past(gross));
	endproperty
	a_fz_full: assert property (p_fz_full)
		else $error("forced zeroing did not take whole gross");

	property p_fz_over;
		clk_en && fz_req && fz_over
			|=> fz_off == 24'($past(fz_off) + $past(zreg_w));
	endproperty
	a_fz_over: assert property (p_fz_over)
		else $error("over-limit zeroing took wrong amount");

	property p_alarm_set;
		clk_en && alarm_set |=> alarm_state == wcu_pkg::WCU_ALM_FLASH;
	endproperty
	a_alarm_set: assert property (p_alarm_set)
		else $error("zero alarm not raised");

	property p_clear;
		clk_en && zero_clear_key && !fz_req && !alarm_set
			|=> fz_off == 24'sh0 && alarm_state == wcu_pkg::WCU_ALM_OFF;
	endproperty
	a_clear: assert property (p_clear)
		else $error("zero clear did not remove offset or alarm");

	property p_reg_hold;
		clk_en && !zero_reg_load |=> zero_reg == $past(zero_reg);
	endproperty
	a_reg_hold: assert property (p_reg_hold)
		else $error("regulation value changed without a load");

	property p_drift_block;
		clk_en && drift_block |=> $stable(drift_off);
	endproperty
	a_drift_block: assert property (p_drift_block)
		else $error("tracking moved zero beyond the limit");

	property p_tare_block;
		clk_en && tare_req && tare_restrict_en && !motion_stable
			|=> $stable(tare_q);
	endproperty
	a_tare_block: assert property (p_tare_block)
		else $error("tare taken while not stable");

	property p_tare_take;
		clk_en && tare_do |=> tare_q == $past(gross) && tare_lit;
	endproperty
	a_tare_take: assert property (p_tare_take)
		else $error("tare not captured");

	c_stable: cover property ($rose(motion_stable));
	c_fz_over: cover property (clk_en && fz_req && fz_over);
	c_tare: cover property (clk_en && tare_do && tare_range_limited);
	c_stall: cover property (disp_valid && !disp_ready && !buf_ready);
endmodule
`default_nettype wire

// >>> verification/wcu_adc_model.sv
// Purpose: converter and contact model feeding the unit
// Assumes: one conversion every ten cycles
// Notes: data shows the inverse between conversions
`timescale 1ns/1ps
`default_nettype none
module wcu_adc_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic signed [23:0] weight,
	input wire logic close_zero, // contact closed to common
	input wire logic close_tare,
	output logic sample_valid,
	output logic signed [23:0] sample_data,
	output logic forced_zeroing_contact_n,
	output logic tare_contact_n
);
	logic [3:0] cnt; // conversion spacing
	// conversion pulse every ten cycles
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) cnt <= 4'h0;
		else cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
	end
	assign sample_valid = (cnt == 4'h9);
	// stale data must never look valid
	assign sample_data = sample_valid ? weight : ~weight;
	// pull-up keeps an open contact high
	assign forced_zeroing_contact_n = !close_zero;
	assign tare_contact_n = !close_tare;
endmodule
`default_nettype wire

// >>> verification/test_weight_conditioning_unit.sv
// Purpose: self-checking bench of the weight path
// Assumes: 20 cycles per tick, one display word per 80 cycles
// Notes: words are read only after the path has settled
`timescale 1ns/1ps
`default_nettype none
module test_weight_conditioning_unit;
	logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, disp_ready = 1'b1;
	logic stable_insert_en = 1'b1, motion_checker = 1'b1, cz = 1'b0, ct = 1'b0;
	logic tare_restrict_en = 1'b1, tare_range_limited = 1'b0;
	logic [8:0] avg_len = 9'h000; // filter off keeps gross exact
	logic [6:0] motion_period = 7'h01, motion_range = 7'h01, drift_period = 7'h00;
	logic [7:0] min_div = 8'h01;
	logic [13:0] drift_range = 14'h0005, zero_reg_in = 14'h03E8;
	logic [1:0] disp_rate_sel = 2'h0;
	wcu_pkg::wcu_sub_type subdisp_sel = wcu_pkg::WCU_SUB_NONE;
	logic [23:0] near_zero_set = 24'h1, upper_set = 24'h2, lower_set = 24'h3;
	logic [23:0] final_set = 24'h4, over_set = 24'h5, under_set = 24'h6;
	logic [23:0] acc_count = 24'h7, acc_latest = 24'h8, acc_total = 24'h9;
	logic [23:0] capacity = 24'h002710;
	logic [3:0] keys = 4'h0; // load, tare, clear, forced zeroing
	logic signed [23:0] weight = 24'h0;
	wire logic sample_valid, forced_zeroing_contact_n, tare_contact_n;
	wire logic signed [23:0] sample_data, disp_net, disp_gross;
	wire logic [23:0] sub_w0, sub_w1, sub_w2;
	wire logic disp_valid, motion_stable, zero_limit_alarm, tare_lit;
	int num_errors = 0, checked = 0;
	// weight, subdisplay choice, then the three expected words
	localparam logic [23:0] ROWS [6][5] = '{
		'{24'h64, 24'h0, 24'h0, 24'h0, 24'h0},
		'{24'hFFFFCE, 24'h1, 24'h1, 24'h2, 24'h3},
		'{24'h0, 24'h2, 24'h4, 24'h5, 24'h6},
		'{24'h7, 24'h3, 24'h7, 24'h8, 24'h4},
		'{24'hFA, 24'h4, 24'h8, 24'h9, 24'h0},
		'{24'h1, 24'h5, 24'h7, 24'h9, 24'h0}};
	wcu_top #(.CENTI_CYCLES(20)) uut (.ref_clk, .resetn, .clk_en, .sample_valid,
		.sample_data, .avg_len, .stable_insert_en, .motion_checker,
		.motion_period, .motion_range, .min_div, .drift_period, .drift_range,
		.zero_reg_load(keys[3]), .zero_reg_in, .forced_zeroing_key(keys[0]),
		.zero_clear_key(keys[1]), .forced_zeroing_contact_n,
		.tare_key(keys[2]), .tare_contact_n, .tare_restrict_en,
		.tare_range_limited, .capacity, .disp_rate_sel, .subdisp_sel,
		.near_zero_set, .upper_set, .lower_set, .final_set, .over_set,
		.under_set, .acc_count, .acc_latest, .acc_total, .disp_ready,
		.disp_valid, .disp_net, .disp_gross, .sub_w0, .sub_w1, .sub_w2,
		.motion_stable, .zero_limit_alarm, .tare_lit);
	wcu_adc_model adc (.ref_clk, .resetn, .weight, .close_zero(cz),
		.close_tare(ct), .sample_valid, .sample_data,
		.forced_zeroing_contact_n, .tare_contact_n);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tmo();
		$display("MISMATCH at %0t: wait ran out", $time);
		num_errors++;
		final_report();
	endtask
	// one-cycle key pulse
	task automatic key(input int k);
		@(posedge ref_clk) keys <= 4'h1 << k;
		@(posedge ref_clk) keys <= 4'h0;
	endtask
	// new weight, given time for a conversion to land
	task automatic setw(input logic [23:0] w);
		@(posedge ref_clk) weight <= w;
		repeat (30) @(posedge ref_clk);
	endtask
	// let old words drain, then catch a fresh one
	task automatic rd(output logic [23:0] g, output logic [23:0] n);
		int i;
		repeat (250) @(negedge ref_clk);
		for (i = 0; i < 500 && disp_valid !== 1'b1; i++) @(negedge ref_clk);
		if (i == 500) tmo();
		g = disp_gross;
		n = disp_net;
	endtask
	task automatic wst();
		int i;
		for (i = 0; i < 5000 && motion_stable !== 1'b1; i++) @(negedge ref_clk);
		if (i == 5000) tmo();
	endtask
	initial begin
		logic [23:0] g, n;
		int i;
		repeat (10) @(posedge ref_clk);
		chk({motion_stable, zero_limit_alarm, tare_lit, disp_valid}, 0);
		resetn <= 1'b1;
		for (int r = 0; r < 6; r++) begin
			@(posedge ref_clk) subdisp_sel <= wcu_pkg::wcu_sub_type'(ROWS[r][1][2:0]);
			setw(ROWS[r][0]);
			rd(g, n);
			chk(g, ROWS[r][0]);
			chk(n, ROWS[r][0]);
			chk(sub_w0, ROWS[r][2]);
			chk(sub_w1, ROWS[r][3]);
			chk(sub_w2, ROWS[r][4]);
		end
		$display("test table done");
		setw(24'h96);
		key(0);
		rd(g, n);
		chk(g, 24'h0);
		key(1);
		rd(g, n);
		chk(g, 24'h96);
		setw(24'h1F4);
		key(0);
		rd(g, n);
		chk(g, 24'h12C);
		for (i = 0; i < 1200 && zero_limit_alarm !== 1'b1; i++) @(negedge ref_clk);
		chk(zero_limit_alarm, 1);
		key(1);
		rd(g, n);
		chk({g, zero_limit_alarm}, {24'h1F4, 1'b0});
		key(3);
		key(0);
		rd(g, n);
		chk(g, 24'h0);
		key(1);
		@(posedge ref_clk) cz <= 1'b1;
		rd(g, n);
		chk(g, 24'h0);
		@(posedge ref_clk) cz <= 1'b0;
		key(1);
		$display("test zeroing done");
		setw(24'h384);
		chk(motion_stable, 0);
		key(2);
		repeat (3) @(negedge ref_clk);
		chk(tare_lit, 0);
		wst();
		key(2);
		rd(g, n);
		chk({n, tare_lit}, {24'h0, 1'b1});
		setw(24'h3AC);
		rd(g, n);
		chk(n, 24'h28);
		wst();
		@(posedge ref_clk) ct <= 1'b1;
		rd(g, n);
		chk(n, 24'h0);
		@(posedge ref_clk) disp_ready <= 1'b0;
		repeat (600) @(negedge ref_clk);
		chk({disp_valid, disp_gross}, {1'b1, 24'h3AC});
		@(posedge ref_clk) disp_ready <= 1'b1;
		$display("test tare done");
		@(posedge ref_clk) drift_period <= 7'h01;
		setw(24'h3);
		repeat (300) @(negedge ref_clk);
		rd(g, n);
		chk(g, 24'h0);
		@(posedge ref_clk) zero_reg_in <= 14'h0000;
		key(3);
		for (i = 0; i < 2500 && zero_limit_alarm !== 1'b1; i++) @(negedge ref_clk);
		chk(zero_limit_alarm, 1);
		@(posedge ref_clk) begin
			drift_period <= 7'h00;
			avg_len <= 9'h100;
			stable_insert_en <= 1'b0;
		end
		repeat (100) @(posedge ref_clk);
		setw(24'h67);
		rd(g, n);
		chk({g > 24'h0, g < 24'h64}, 2'h3);
		$display("test tracking done");
		final_report();
	end
endmodule
`default_nettype wire
